//--- logic/line_mode_ctrl.sv
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// How it works
// [R1] Power-down low with both selects low is power down, power-down high with both low is high-impedance feed, polarity ignored.
// [R2] Power-down high with select b high is active, select a adds metering tone and polarity select picks reverse polarity.
// [R3] Power-down high, select a high, select b low is ringing, with the controller toggling polarity select at the ring rate.
// [R4] Loop status leaves on one active-low open-drain output that is only ever pulled low.
// [R5] Power down floats both line terminals, blanks the detectors and stops voice transmission.
// [R6] Thermal overload forces power down whatever the selects say and the selected mode returns once it clears.
// [R7] High-impedance feed pulls the loop-detect output low on off-hook with the active threshold and passes no voice.
// [R8] Line polarity follows polarity select and swaps through a gradual ramp instead of a step.
// [R9] In active mode select a gates metering tone, so its high time is the metering pulse length.
// [R10] The controller supplies a 12 or 16 kHz tone clock for the whole metering pulse.
// [R11] The converter follows an external 125 kHz clock, or an internal one when its pin is tied to the supply filter.
// [R12] In active mode the gain-set bit picks the transmit and receive gain pair.
// [R13] Ringing raises the battery target to the ringing value and any other mode returns it to on-hook.
// [R14] In ringing the polarity select gives direct at 0 and reverse at 1, forming a trapezoidal ring.
// [R15] Ring trip pulls loop-detect low and the controller then stops toggling and moves the device on.
// [R16] The controller synchronises loop-detect through two flip-flops before acting on it.
module line_mode_ctrl
    import line_if_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Control pins
    input wire logic power_down_n_input,
    input wire logic mode_select_a,
    input wire logic mode_select_b,
    input wire logic polarity_select,
    input wire logic meter_tone_clock,
    input wire logic thermal_overload,
    input wire logic off_hook_sense,
    input wire logic ring_trip_sense,
    input wire logic conv_clk_ext,
    input wire logic conv_clk_tied,
    // Open-drain loop detect
    output logic loop_detect_n_out,
    output logic loop_detect_n_oe,
    // Line-side controls
    output logic line_terminals_hiz,
    output logic voice_tx_enable,
    output logic battery_ring_target,
    output logic meter_enable,
    output logic meter_tone_out,
    output logic gain_high,
    output logic [LEVEL_W-1:0] polarity_level,
    output logic conv_sync_clk,
    output logic irq
);

    typedef struct packed {
        pins_t s1;
        pins_t s2;
        mode_t mode;
        logic loop_detect_n;
        logic thermal;
        logic line_hiz;
        logic tx_en;
        logic bat_ring;
        logic meter_en;
        logic meter_tone;
        logic gain_sel;
        logic pol_target;
        logic conv_clk;
        logic [CONV_CNT_W-1:0] conv_cnt;
        logic gain_cfg;
        logic [RAMP_W-1:0] ramp_div;
        logic [IRQ_W-1:0] irq_sts;
        logic [IRQ_W-1:0] irq_msk;
        logic irq;
        logic aw_full;
        logic w_full;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_t;

    state_t q;
    state_t d;
    logic [LEVEL_W-1:0] ramp_level;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic mode_t decode_mode(input pins_t p);
        if (!p.power_down_n_input) begin
            decode_mode = MODE_POWER_DOWN; // see [R1]
        end else if (p.mode_select_b) begin
            decode_mode = MODE_ACTIVE; // see [R2]
        end else if (p.mode_select_a) begin
            decode_mode = MODE_RINGING; // see [R3]
        end else begin
            decode_mode = MODE_HIZ_FEED; // see [R1]
        end
    endfunction : decode_mode

    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        merge_strb = r;
    endfunction : merge_strb

    function automatic logic [31:0] ctrl_word(input state_t s);
        logic [31:0] r;
        r = '0;
        r[CTRL_GAIN_BIT] = s.gain_cfg;
        r[CTRL_RAMP_LSB +: RAMP_W] = s.ramp_div;
        ctrl_word = r;
    endfunction : ctrl_word

    ////////////////////////////////////////////////////////////////////////
    // Polarity ramp

    polarity_ramp u_ramp (
        .aclk(aclk),
        .aresetn(aresetn),
        .reverse(q.pol_target),
        .step_div(q.ramp_div),
        .level(ramp_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [31:0] wr_v;
        logic [31:0] sts_v;
        logic [IRQ_W-1:0] ev;
        logic do_wr;
        mode_t sel_mode;
        wr_v = '0;
        sts_v = '0;
        ev = '0;
        do_wr = 1'b0;
        d = q;

        // Two-stage synchroniser; only s2 is read beyond this point
        d.s1 = '{
            power_down_n_input: power_down_n_input,
            mode_select_a: mode_select_a,
            mode_select_b: mode_select_b,
            polarity_select: polarity_select,
            meter_tone_clock: meter_tone_clock,
            thermal_overload: thermal_overload,
            off_hook_sense: off_hook_sense,
            ring_trip_sense: ring_trip_sense,
            conv_clk_ext: conv_clk_ext,
            conv_clk_tied: conv_clk_tied
        };
        d.s2 = q.s1;

        // Mode selection with thermal override
        sel_mode = decode_mode(q.s2);
        d.thermal = q.s2.thermal_overload;
        if (q.s2.thermal_overload) begin
            d.mode = MODE_POWER_DOWN; // see [R6]
        end else begin
            d.mode = sel_mode; // see [R6]
        end

        // Loop detection per mode
        case (d.mode)
            MODE_POWER_DOWN: d.loop_detect_n = 1'b0; // see [R5]
            MODE_HIZ_FEED: d.loop_detect_n = q.s2.off_hook_sense; // see [R7]
            MODE_ACTIVE: d.loop_detect_n = q.s2.off_hook_sense;
            MODE_RINGING: d.loop_detect_n = q.s2.ring_trip_sense; // see [R15]
            default: d.loop_detect_n = 1'b0;
        endcase

        // Line-side outputs
        d.line_hiz = (d.mode == MODE_POWER_DOWN); // see [R5]
        d.tx_en = (d.mode == MODE_ACTIVE); // see [R5] [R7]
        d.bat_ring = (d.mode == MODE_RINGING); // see [R13]
        d.meter_en = (d.mode == MODE_ACTIVE) && q.s2.mode_select_a; // see [R9]
        d.meter_tone = d.meter_en && q.s2.meter_tone_clock; // see [R9]
        d.gain_sel = (d.mode == MODE_ACTIVE) && q.gain_cfg; // see [R12]
        if (d.mode == MODE_ACTIVE || d.mode == MODE_RINGING) begin
            d.pol_target = q.s2.polarity_select; // see [R8] [R14]
        end

        // Converter clock: internal divider or synchronised external
        if (q.s2.conv_clk_tied) begin
            if (q.conv_cnt == CONV_CNT_W'(CONV_HALF_CYCLES - 1)) begin
                d.conv_cnt = '0;
                d.conv_clk = !q.conv_clk; // see [R11]
            end else begin
                d.conv_cnt = q.conv_cnt + 9'h001;
            end
        end else begin
            d.conv_cnt = '0;
            d.conv_clk = q.s2.conv_clk_ext; // see [R11]
        end

        // Events
        ev[IRQ_OFF_HOOK] = d.loop_detect_n && !q.loop_detect_n && (d.mode != MODE_RINGING);
        ev[IRQ_RING_TRIP] = d.loop_detect_n && !q.loop_detect_n && (d.mode == MODE_RINGING);
        ev[IRQ_THERMAL] = q.s2.thermal_overload && !q.thermal;
        ev[IRQ_MODE] = (d.mode != q.mode);

        // AXI write channel
        if (s_axi_awvalid && q.awready) begin
            d.aw_full = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_full = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.aw_full && q.w_full && !q.bvalid) begin
            do_wr = 1'b1;
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        d.awready = !d.aw_full && !d.bvalid;
        d.wready = !d.w_full && !d.bvalid;

        if (do_wr) begin
            if (q.awaddr == ADDR_CTRL) begin
                wr_v = merge_strb(ctrl_word(q), q.wdata, q.wstrb);
                d.gain_cfg = wr_v[CTRL_GAIN_BIT];
                d.ramp_div = wr_v[CTRL_RAMP_LSB +: RAMP_W];
            end else if (q.awaddr == ADDR_STATUS) begin
                d.bresp = RESP_OKAY;
            end else if (q.awaddr == ADDR_IRQ_STATUS) begin
                wr_v = merge_strb('0, q.wdata, q.wstrb);
                d.irq_sts = q.irq_sts & ~wr_v[IRQ_W-1:0];
            end else if (q.awaddr == ADDR_IRQ_MASK) begin
                wr_v = merge_strb(32'(q.irq_msk), q.wdata, q.wstrb);
                d.irq_msk = wr_v[IRQ_W-1:0];
            end else begin
                d.bresp = RESP_SLVERR;
            end
        end
        // New events win over a clear in the same cycle
        d.irq_sts = d.irq_sts | ev;
        d.irq = |(d.irq_sts & d.irq_msk);

        // AXI read channel
        sts_v[STS_MODE_LSB +: 2] = q.mode;
        sts_v[STS_DET_BIT] = q.loop_detect_n;
        sts_v[STS_THERMAL_BIT] = q.thermal;
        sts_v[STS_POL_BIT] = q.pol_target;
        sts_v[STS_CLK_INT_BIT] = q.s2.conv_clk_tied;
        sts_v[STS_LEVEL_LSB +: LEVEL_W] = ramp_level;
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            if (s_axi_araddr == ADDR_CTRL) begin
                d.rdata = ctrl_word(q);
            end else if (s_axi_araddr == ADDR_STATUS) begin
                d.rdata = sts_v;
            end else if (s_axi_araddr == ADDR_IRQ_STATUS) begin
                d.rdata = 32'(q.irq_sts);
            end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
                d.rdata = 32'(q.irq_msk);
            end else begin
                d.rdata = '0;
                d.rresp = RESP_SLVERR;
            end
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        d.arready = !d.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.mode <= MODE_POWER_DOWN;
            q.line_hiz <= 1'b1;
            q.gain_cfg <= CTRL_GAIN_RESET;
            q.ramp_div <= CTRL_RAMP_RESET;
            q.irq_msk <= IRQ_MASK_RESET;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bresp = q.bresp;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_arready = q.arready;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rvalid = q.rvalid;
    // Open drain: the pad only ever pulls low
    assign loop_detect_n_out = 1'b0; // see [R4]
    assign loop_detect_n_oe = q.loop_detect_n; // see [R4] [R7] [R15]
    assign line_terminals_hiz = q.line_hiz;
    assign voice_tx_enable = q.tx_en;
    assign battery_ring_target = q.bat_ring;
    assign meter_enable = q.meter_en;
    assign meter_tone_out = q.meter_tone;
    assign gain_high = q.gain_sel;
    assign polarity_level = ramp_level;
    assign conv_sync_clk = q.conv_clk;
    assign irq = q.irq;

endmodule : line_mode_ctrl
`default_nettype wire

//--- logic/line_if_pkg.sv
`default_nettype none
package line_if_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'hC;

    // Control register fields
    localparam int CTRL_GAIN_BIT = 0;
    localparam int CTRL_RAMP_LSB = 8;
    localparam int RAMP_W = 8;
    localparam logic CTRL_GAIN_RESET = 1'b0;
    localparam logic [RAMP_W-1:0] CTRL_RAMP_RESET = 8'h10;

    // Status register fields
    localparam int STS_MODE_LSB = 0;
    localparam int STS_DET_BIT = 2;
    localparam int STS_THERMAL_BIT = 3;
    localparam int STS_POL_BIT = 4;
    localparam int STS_CLK_INT_BIT = 5;
    localparam int STS_LEVEL_LSB = 8;

    // Interrupt bits, same layout in status and mask
    localparam int IRQ_W = 4;
    localparam int IRQ_OFF_HOOK = 0;
    localparam int IRQ_RING_TRIP = 1;
    localparam int IRQ_THERMAL = 2;
    localparam int IRQ_MODE = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

    // Polarity ramp level: 0 is direct, all ones is reverse
    localparam int LEVEL_W = 8;
    localparam logic [LEVEL_W-1:0] LEVEL_DIRECT = 8'h00;
    localparam logic [LEVEL_W-1:0] LEVEL_REVERSE = 8'hFF;

    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int CONV_CLK_HZ = 125_000;
    localparam int CONV_HALF_CYCLES = CLK_HZ / (2 * CONV_CLK_HZ);
    localparam int CONV_CNT_W = 9;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_POWER_DOWN,
        MODE_HIZ_FEED,
        MODE_ACTIVE,
        MODE_RINGING
    } mode_t;

    // Pin inputs, passed through a two-stage synchroniser as a group
    typedef struct packed {
        logic power_down_n_input;
        logic mode_select_a;
        logic mode_select_b;
        logic polarity_select;
        logic meter_tone_clock;
        logic thermal_overload;
        logic off_hook_sense;
        logic ring_trip_sense;
        logic conv_clk_ext;
        logic conv_clk_tied;
    } pins_t;

endpackage : line_if_pkg
`default_nettype wire

//--- logic/polarity_ramp.sv
`timescale 1ns/100ps
`default_nettype none
module polarity_ramp
    import line_if_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic reverse,
    input wire logic [RAMP_W-1:0] step_div,
    output logic [LEVEL_W-1:0] level
);

    typedef struct packed {
        logic [LEVEL_W-1:0] level;
        logic [RAMP_W-1:0] div_cnt;
    } ramp_state_t;

    ramp_state_t q;
    ramp_state_t d;

    ////////////////////////////////////////////////////////////////////////
    // Step one level toward the target every step_div+1 cycles
    always_comb begin
        d = q;
        if (q.div_cnt >= step_div) begin
            d.div_cnt = '0;
            if (reverse && q.level != LEVEL_REVERSE) begin
                d.level = q.level + 8'h01; // see [R8]
            end else if (!reverse && q.level != LEVEL_DIRECT) begin
                d.level = q.level - 8'h01; // see [R8]
            end
        end else begin
            d.div_cnt = q.div_cnt + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q.level <= LEVEL_DIRECT;
            q.div_cnt <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.level;

endmodule : polarity_ramp
`default_nettype wire

//--- tb/line_mode_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
module line_mode_ctrl_checker
    import line_if_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic power_down_n_input,
    input wire logic mode_select_a,
    input wire logic mode_select_b,
    input wire logic thermal_overload,
    input wire logic off_hook_sense,
    input wire logic ring_trip_sense,
    input wire logic loop_detect_n_out,
    input wire logic loop_detect_n_oe,
    input wire logic line_terminals_hiz,
    input wire logic voice_tx_enable,
    input wire logic battery_ring_target,
    input wire logic meter_enable,
    input wire logic meter_tone_out,
    input wire logic [LEVEL_W-1:0] polarity_level
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////
    // Pin history; checks only once the pins have stood for two edges
    logic [5:0] h1_q, h2_q, h3_q, h4_q;
    logic [2:0] up_q;
    logic st, pd, act, ring, hiz;
    always_ff @(posedge aclk) begin
        h1_q <= {power_down_n_input, mode_select_a, mode_select_b,
            thermal_overload, off_hook_sense, ring_trip_sense};
        h2_q <= h1_q;
        h3_q <= h2_q;
        h4_q <= h3_q;
        up_q <= !aresetn ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
    end
    assign st = (up_q == 3'h7) && (h3_q == h4_q);
    assign pd = !h3_q[5] || h3_q[2];
    assign act = !pd && h3_q[3];
    assign ring = !pd && h3_q[4] && !h3_q[3];
    assign hiz = !pd && !h3_q[4] && !h3_q[3];

    ////////////////////////////////////////////////////////////////////////
    property p_power_down;
        st && pd |-> line_terminals_hiz && !voice_tx_enable && !loop_detect_n_oe;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power down outputs wrong");
    property p_hiz_feed;
        st && hiz |-> !line_terminals_hiz && !voice_tx_enable
            && (loop_detect_n_oe == h3_q[1]);
    endproperty
    a_hiz_feed: assert property (p_hiz_feed)
        else $error("hiz feed outputs wrong");
    property p_active;
        st && act |-> voice_tx_enable && (meter_enable == h3_q[4])
            && (loop_detect_n_oe == h3_q[1]);
    endproperty
    a_active: assert property (p_active)
        else $error("active outputs wrong");
    property p_ringing;
        st && ring |-> battery_ring_target && !voice_tx_enable
            && (loop_detect_n_oe == h3_q[0]);
    endproperty
    a_ringing: assert property (p_ringing)
        else $error("ringing outputs wrong");
    property p_battery;
        st && !ring |-> !battery_ring_target;
    endproperty
    a_battery: assert property (p_battery)
        else $error("ring battery outside ringing");
    property p_open_drain;
        loop_detect_n_oe |-> !loop_detect_n_out;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("loop detect driven high");
    property p_ramp_step;
        $changed(polarity_level) |->
            (polarity_level - $past(polarity_level) == 8'h01)
            || ($past(polarity_level) - polarity_level == 8'h01);
    endproperty
    a_ramp_step: assert property (p_ramp_step)
        else $error("polarity level jumped");
    property p_meter_tone;
        meter_tone_out |-> meter_enable;
    endproperty
    a_meter_tone: assert property (p_meter_tone)
        else $error("tone without metering");
endmodule : line_mode_ctrl_checker

bind line_mode_ctrl line_mode_ctrl_checker checker_i (.*);
`default_nettype wire

//--- tb/line_controller_model.sv
`timescale 1ns/100ps
`default_nettype none
module line_controller_model #(
    parameter int TONE_HALF = 1667,
    parameter int RING_HALF = 400
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ring_en,
    input wire logic loop_detect_n_out,
    input wire logic loop_detect_n_oe,
    output logic meter_tone_clock,
    output logic ring_pol,
    output logic det_n_sync
);
    logic det_m;
    int tone_cnt;
    int ring_cnt;
    always_ff @(posedge aclk) begin
        // Pull-up holds the line high unless the device sinks it
        det_m <= loop_detect_n_oe ? loop_detect_n_out : 1'b1;
        det_n_sync <= det_m;
        if (!aresetn || tone_cnt == TONE_HALF - 1) begin
            tone_cnt <= 0;
            meter_tone_clock <= aresetn && !meter_tone_clock;
        end else begin
            tone_cnt <= tone_cnt + 1;
        end
        if (!ring_en || !det_n_sync) begin
            ring_cnt <= 0;
            ring_pol <= 1'b0;
        end else if (ring_cnt == RING_HALF - 1) begin
            ring_cnt <= 0;
            ring_pol <= !ring_pol;
        end else begin
            ring_cnt <= ring_cnt + 1;
        end
    end
endmodule : line_controller_model
`default_nettype wire

//--- tb/line_mode_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module line_mode_ctrl_tb_top
    import line_if_pkg::*;
;
    logic aclk, aresetn;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic power_down_n_input, mode_select_a, mode_select_b, polarity_select;
    logic meter_tone_clock, thermal_overload, off_hook_sense, ring_trip_sense;
    logic conv_clk_ext, conv_clk_tied, loop_detect_n_out, loop_detect_n_oe;
    logic line_terminals_hiz, voice_tx_enable, battery_ring_target;
    logic meter_enable, meter_tone_out, gain_high, conv_sync_clk, irq;
    logic [LEVEL_W-1:0] polarity_level;
    logic pol_q, ring_en, ring_pol, det_n_sync, conv_prev;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    // Pins {power down n, select a, select b, polarity}, expected mode
    localparam logic [5:0] TBL [9] = '{6'h00, 6'h04, 6'h21, 6'h25, 6'h2A,
        6'h2E, 6'h3A, 6'h3E, 6'h33};

    assign polarity_select = ring_en ? ring_pol : pol_q;
    line_mode_ctrl dut (.*);
    line_controller_model partner (.*);

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : rd

    // Pins {pd_n, a, b, polarity, thermal, off-hook, ring trip}
    task automatic drive(input logic [6:0] v);
        @(posedge aclk);
        {power_down_n_input, mode_select_a, mode_select_b, pol_q,
            thermal_overload, off_hook_sense, ring_trip_sense} <= v;
        repeat (8) @(posedge aclk);
    endtask : drive

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        {power_down_n_input, mode_select_a, mode_select_b, pol_q} = 4'h0;
        {thermal_overload, off_hook_sense, ring_trip_sense} = 3'h0;
        {conv_clk_ext, conv_clk_tied, ring_en} = 3'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(line_terminals_hiz, 1'b1);
        rd(ADDR_CTRL);
        chk(d, {16'h0, CTRL_RAMP_RESET, 7'h0, CTRL_GAIN_RESET});
        rd(ADDR_IRQ_MASK);
        chk(d, {28'h0, IRQ_MASK_RESET});
        rd(4'h2);
        chk(d, 32'h0);
        chk(r, RESP_SLVERR);
        wr(4'h6, 32'hFF);
        chk(r, RESP_SLVERR);
        $display("test registers done");
        for (int i = 0; i < 9; i++) begin
            drive({TBL[i][5:2], 3'h0});
            rd(ADDR_STATUS);
            chk(d[1:0], TBL[i][1:0]);
            chk(meter_enable, TBL[i][5:3] == 3'h7);
            chk(battery_ring_target, TBL[i][1:0] == 2'h3);
            chk(voice_tx_enable, TBL[i][1:0] == 2'h2);
            chk(line_terminals_hiz, TBL[i][1:0] == 2'h0);
        end
        $display("test modes done");
        wr(ADDR_IRQ_STATUS, 32'hF);
        drive(7'h42);
        chk(det_n_sync, 1'b0);
        rd(ADDR_IRQ_STATUS);
        chk({d[0], irq}, 2'h2);
        wr(ADDR_IRQ_MASK, 32'h1);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b1);
        drive(7'h02);
        chk(det_n_sync, 1'b1);
        drive(7'h00);
        wr(ADDR_IRQ_STATUS, 32'hF);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b0);
        $display("test detect done");
        drive(7'h54);
        rd(ADDR_STATUS);
        chk({d[1:0], line_terminals_hiz}, 3'h1);
        drive(7'h50);
        rd(ADDR_STATUS);
        chk(d[1:0], 2'h2);
        wr(ADDR_CTRL, 32'h1);
        repeat (3) @(posedge aclk);
        chk(gain_high, 1'b1);
        drive(7'h58);
        repeat (20) @(posedge aclk);
        chk(polarity_level != 8'h0 && polarity_level != 8'hFF, 1'b1);
        repeat (300) @(posedge aclk);
        chk(polarity_level, LEVEL_REVERSE);
        drive(7'h40);
        chk(gain_high, 1'b0);
        $display("test active done");
        @(posedge aclk);
        ring_en <= 1'b1;
        drive(7'h60);
        repeat (1000) @(posedge aclk);
        chk(battery_ring_target, 1'b1);
        drive(7'h61);
        chk(det_n_sync, 1'b0);
        ring_en <= 1'b0;
        drive(7'h50);
        chk(battery_ring_target, 1'b0);
        drive(7'h70);
        @(posedge meter_tone_clock);
        repeat (4) @(posedge aclk);
        chk(meter_tone_out, 1'b1);
        conv_clk_ext <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(conv_sync_clk, 1'b1);
        conv_clk_tied <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(ADDR_STATUS);
        chk(d[5], 1'b1);
        conv_prev = conv_sync_clk;
        repeat (CONV_HALF_CYCLES) @(posedge aclk);
        chk(conv_sync_clk, !conv_prev);
        $display("test ringing done");
        print_verdict();
    end
endmodule : line_mode_ctrl_tb_top
`default_nettype wire
